// file: hw/tdr_pkg.sv
// package of constants and types for the tap detector and interrupt routing
package tdr_pkg;
  // source select codes of an interrupt pad
  localparam logic [2:0] SEL_GND      = 3'h0;
  localparam logic [2:0] SEL_MOTION1  = 3'h1;
  localparam logic [2:0] SEL_MOTION2  = 3'h2;
  localparam logic [2:0] SEL_MOTION12 = 3'h3;
  localparam logic [2:0] SEL_DRDY     = 3'h4;
  localparam logic [2:0] SEL_TAP      = 3'h7;
  localparam logic [2:0] SEL_RESET    = 3'h0;
  localparam logic       POL_RESET    = 1'b0;
  // register offsets
  localparam logic [3:0] OFS_ROUTE    = 4'h0;
  localparam logic [3:0] OFS_TAPCFG   = 4'h1;
  localparam logic [3:0] OFS_DURATION = 4'h2;
  localparam logic [3:0] OFS_QUIET    = 4'h3;
  localparam logic [3:0] OFS_WINDOW   = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;
  localparam logic [3:0] OFS_MASK     = 4'h6;
  // route register fields
  localparam int ROUTE_SEL1_LSB = 0;
  localparam int ROUTE_SEL2_LSB = 3;
  localparam int ROUTE_POL_BIT  = 7;
  // tap config fields
  localparam int TAPCFG_SINGLE_BIT = 0;
  localparam int TAPCFG_DOUBLE_BIT = 1;
  localparam logic [1:0] TAPCFG_RESET  = 2'h0;
  localparam logic [7:0] TIMING_RESET  = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;
  // status bits
  localparam int STATUS_SINGLE_BIT = 0;
  localparam int STATUS_DOUBLE_BIT = 1;
  // timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int HALF_MS_US   = 500;
  localparam int HALF_MS_CYC  = CLK_HZ / 1_000_000 * HALF_MS_US;
  // tap detector states
  typedef enum logic [4:0] {
    TS_IDLE   = 5'b00001,
    TS_PEAK1  = 5'b00010,
    TS_QUIET  = 5'b00100,
    TS_WINDOW = 5'b01000,
    TS_PEAK2  = 5'b10000
  } tdr_tap_state_t;
endpackage

// file: hw/tdr_tick_if.sv
// interface carrying the time base ticks to the tap detector
`timescale 1ns/1ns
`default_nettype none
interface tdr_tick_if;
  logic halfMs;
  logic oneMs;
  modport src (output halfMs, output oneMs);
  modport dst (input halfMs, input oneMs);
endinterface
`default_nettype wire

// file: hw/tdr_timebase.sv
// divider giving 0.5 ms and 1 ms enable pulses
`timescale 1ns/1ns
`default_nettype none
module tdr_timebase #(
  parameter int HALF_CYC = 50000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // ticks
  tdr_tick_if.src   tick
);
  import tdr_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic        odd;
    logic        halfMs;
    logic        oneMs;
  } tdr_tb_st_t;
  tdr_tb_st_t st_r;
  tdr_tb_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.halfMs = 1'b0;
    st_nxt.oneMs = 1'b0;
    if (st_r.cnt == 32'(HALF_CYC - 1)) begin
      st_nxt.cnt = 32'h0;
      st_nxt.halfMs = 1'b1;
      st_nxt.oneMs = st_r.odd;
      st_nxt.odd = ~st_r.odd;
    end else begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign tick.halfMs = st_r.halfMs;
  assign tick.oneMs = st_r.oneMs;
endmodule
`default_nettype wire

// file: hw/tdr_tap_fsm.sv
// single and double tap timing detector
`timescale 1ns/1ns
`default_nettype none
module tdr_tap_fsm (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // time base
  tdr_tick_if.dst         tick,
  // configuration
  input  wire logic       singleEn,
  input  wire logic       doubleEn,
  input  wire logic [7:0] durationLimit,
  input  wire logic [7:0] quietTime,
  input  wire logic [7:0] tapWindow,
  // acceleration above threshold
  input  wire logic       overThreshold,
  // events
  output logic            singleTap,
  output logic            doubleTap
);
  import tdr_pkg::*;
  typedef struct packed {
    tdr_tap_state_t state;
    logic [8:0]     cnt;
    logic           prevOver;
    logic           singleTap;
    logic           doubleTap;
  } tdr_tap_st_t;
  tdr_tap_st_t st_r;
  tdr_tap_st_t st_nxt;
  logic rise;
  logic fall;
  always_comb begin
    rise = overThreshold & ~st_r.prevOver;
    fall = ~overThreshold & st_r.prevOver;
    st_nxt = st_r;
    st_nxt.prevOver = overThreshold;
    st_nxt.singleTap = 1'b0;
    st_nxt.doubleTap = 1'b0;
    unique case (st_r.state)
      TS_IDLE: begin
        if (rise && (singleEn || doubleEn)) begin
          st_nxt.state = TS_PEAK1;
          st_nxt.cnt = 9'h0;
        end
      end
      TS_PEAK1, TS_PEAK2: begin
        if (fall) begin
          if (st_r.state == TS_PEAK2) begin
            st_nxt.doubleTap = 1'b1;
            st_nxt.state = TS_IDLE;
          end else begin
            st_nxt.singleTap = singleEn;
            st_nxt.state = doubleEn ? TS_QUIET : TS_IDLE;
            st_nxt.cnt = 9'h0;
          end
        end else if (tick.halfMs) begin
          if (st_r.cnt[7:0] >= durationLimit) begin
            st_nxt.state = TS_IDLE;
          end else begin
            st_nxt.cnt = st_r.cnt + 9'h1;
          end
        end
      end
      TS_QUIET: begin
        // peaks ignored while quiet
        if (tick.oneMs) begin
          if (st_r.cnt[7:0] >= quietTime) begin
            st_nxt.state = TS_WINDOW;
            st_nxt.cnt = 9'h0;
          end else begin
            st_nxt.cnt = st_r.cnt + 9'h1;
          end
        end
      end
      TS_WINDOW: begin
        // window follows quiet time
        if (rise) begin
          st_nxt.state = TS_PEAK2;
          st_nxt.cnt = 9'h0;
        end else if (tick.oneMs) begin
          if (st_r.cnt[7:0] >= tapWindow) begin
            // late second peak gives no double tap
            st_nxt.state = TS_IDLE;
          end else begin
            st_nxt.cnt = st_r.cnt + 9'h1;
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{state: TS_IDLE, cnt: 9'h0, prevOver: 1'b0, singleTap: 1'b0, doubleTap: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign singleTap = st_r.singleTap;
  assign doubleTap = st_r.doubleTap;
endmodule
`default_nettype wire

// file: hw/tdr_top.sv
// tap detector with interrupt pad routing and register port
`timescale 1ns/1ns
`default_nettype none
module tdr_top #(
  parameter int HALF_CYC = tdr_pkg::HALF_MS_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // internal event sources
  input  wire logic       motionEventFirst,
  input  wire logic       motionEventSecond,
  input  wire logic       dataReady,
  input  wire logic       overThreshold,
  // pads and interrupt
  output logic            irqPinFirst,
  output logic            irqPinSecond,
  output logic            irq
);
  import tdr_pkg::*;
  typedef struct packed {
    logic [2:0] pad1Sel;
    logic [2:0] pad2Sel;
    logic       pol;
    logic [1:0] tapCfg;
    logic [7:0] duration;
    logic [7:0] quiet;
    logic [7:0] window;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic       pin1;
    logic       pin2;
    logic       irq;
  } tdr_top_st_t;
  tdr_top_st_t st_r;
  tdr_top_st_t st_nxt;
  logic singleTap;
  logic doubleTap;
  logic tapIrq;
  tdr_tick_if tick ();
  tdr_timebase #(.HALF_CYC(HALF_CYC)) u_tb (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );
  tdr_tap_fsm u_tap (
    .clk           (clk),
    .rstn          (rstn),
    .tick          (tick),
    .singleEn      (st_r.tapCfg[TAPCFG_SINGLE_BIT]),
    .doubleEn      (st_r.tapCfg[TAPCFG_DOUBLE_BIT]),
    .durationLimit (st_r.duration),
    .quietTime     (st_r.quiet),
    .tapWindow     (st_r.window),
    .overThreshold (overThreshold),
    .singleTap     (singleTap),
    .doubleTap     (doubleTap)
  );
  function automatic logic route(input logic [2:0] sel, input logic m1, input logic m2,
                                 input logic dr, input logic tp);
    logic v;
    v = 1'b0;
    unique case (sel)
      SEL_MOTION1:  v = m1;
      SEL_MOTION2:  v = m2;
      SEL_MOTION12: v = m1 | m2;
      SEL_DRDY:     v = dr;
      SEL_TAP:      v = tp;
      default:      v = 1'b0; // ground and codes 101, 110
    endcase
    return v;
  endfunction
  always_comb begin
    tapIrq = |st_r.status;
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    if (regWrite) begin
      unique case (regAddr)
        OFS_ROUTE: begin
          st_nxt.pad1Sel = regWdata[ROUTE_SEL1_LSB +: 3];
          st_nxt.pad2Sel = regWdata[ROUTE_SEL2_LSB +: 3];
          st_nxt.pol = regWdata[ROUTE_POL_BIT];
        end
        OFS_TAPCFG:   st_nxt.tapCfg = regWdata[1:0];
        OFS_DURATION: st_nxt.duration = regWdata;
        OFS_QUIET:    st_nxt.quiet = regWdata;
        OFS_WINDOW:   st_nxt.window = regWdata;
        OFS_MASK:     st_nxt.mask = regWdata[1:0];
        default: ;
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        OFS_ROUTE:    st_nxt.rdata = {st_r.pol, 1'b0, st_r.pad2Sel, st_r.pad1Sel};
        OFS_TAPCFG:   st_nxt.rdata = {6'h00, st_r.tapCfg};
        OFS_DURATION: st_nxt.rdata = st_r.duration;
        OFS_QUIET:    st_nxt.rdata = st_r.quiet;
        OFS_WINDOW:   st_nxt.rdata = st_r.window;
        OFS_STATUS: begin
          st_nxt.rdata = {6'h00, st_r.status};
          st_nxt.status = 2'h0;
        end
        OFS_MASK:     st_nxt.rdata = {6'h00, st_r.mask};
        default:      st_nxt.rdata = 8'h00;
      endcase
    end
    // set wins over the read clear
    if (singleTap) begin
      st_nxt.status[STATUS_SINGLE_BIT] = 1'b1;
    end
    if (doubleTap) begin
      st_nxt.status[STATUS_DOUBLE_BIT] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    st_nxt.pin1 = st_nxt.pol ^ route(st_nxt.pad1Sel, motionEventFirst, motionEventSecond,
                                     dataReady, tapIrq);
    st_nxt.pin2 = st_nxt.pol ^ route(st_nxt.pad2Sel, motionEventFirst, motionEventSecond,
                                     dataReady, tapIrq);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{pad1Sel: SEL_RESET, pad2Sel: SEL_RESET, pol: POL_RESET,
                tapCfg: TAPCFG_RESET, duration: TIMING_RESET, quiet: TIMING_RESET,
                window: TIMING_RESET, status: IRQ_RESET, mask: IRQ_RESET,
                rdata: 8'h00, pin1: 1'b0, pin2: 1'b0, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign regRdata = st_r.rdata;
  assign irqPinFirst = st_r.pin1;
  assign irqPinSecond = st_r.pin2;
  assign irq = st_r.irq;
endmodule
`default_nettype wire

// file: test/tdr_asserts.sv
// checker of the tap detector and pad routing ports
`timescale 1ns/1ns
`default_nettype none
module tdr_asserts (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  // sources and pads
  input wire logic       motionEventFirst,
  input wire logic       motionEventSecond,
  input wire logic       dataReady,
  input wire logic       overThreshold,
  input wire logic       irqPinFirst,
  input wire logic       irqPinSecond,
  input wire logic       irq
);
  import tdr_pkg::*;
  logic [7:0] route_r;
  // shadow of the routing register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) route_r <= 8'h00;
    // bit 6 is reserved and reads back as zero
    else if (regWrite && regAddr == OFS_ROUTE) route_r <= {regWdata[7], 1'b0, regWdata[5:0]};
  end
  function automatic logic srcOf(logic [2:0] s, logic m1, logic m2, logic d, logic t);
    case (s)
      3'h1: return m1;
      3'h2: return m2;
      3'h3: return m1 | m2;
      3'h4: return d;
      3'h7: return t;
      default: return 1'b0;
    endcase
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence statusRead;
    regRead && regAddr == OFS_STATUS;
  endsequence
  sequence calmLevel;
    !overThreshold [*4];
  endsequence
  // the pads show the tap status of one cycle back; irq carries it while the mask covers it
  chk_pad1_route: assert property (
    irqPinFirst == (route_r[7] ^ srcOf(route_r[2:0], $past(motionEventFirst),
    $past(motionEventSecond), $past(dataReady), $past(irq))))
    else $error("pad one level wrong");
  chk_pad2_route: assert property (
    irqPinSecond == (route_r[7] ^ srcOf(route_r[5:3], $past(motionEventFirst),
    $past(motionEventSecond), $past(dataReady), $past(irq))))
    else $error("pad two level wrong");
  chk_reset_pads: assert property (
    !$past(rstn) |-> !irqPinFirst && !irqPinSecond && !irq) else $error("pads after reset");
  chk_rdata_idle: assert property (
    !$past(regRead) |-> regRdata == 8'h00) else $error("read data without read");
  chk_unmapped_read: assert property (
    $past(regRead) && $past(regAddr) > OFS_MASK |-> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_route_readback: assert property (
    $past(regRead) && $past(regAddr) == OFS_ROUTE |-> regRdata == route_r)
    else $error("routing readback wrong");
  chk_read_clears: assert property (
    calmLevel ##0 statusRead |=> !irq) else $error("status read left irq high");
  chk_irq_cause: assert property (
    $rose(irq) |-> $past(regWrite) || !$past(overThreshold)) else $error("irq without tap");
endmodule
`default_nettype wire

// file: test/tdr_host_model.sv
// host model decoding the interrupt pad levels
`timescale 1ns/1ns
`default_nettype none
module tdr_host_model (
  // pads
  input  wire logic padFirst,
  input  wire logic padSecond,
  // programmed polarity
  input  wire logic activeLow,
  // decoded events
  output logic      eventFirst,
  output logic      eventSecond
);
  assign eventFirst  = padFirst ^ activeLow;
  assign eventSecond = padSecond ^ activeLow;
endmodule
`default_nettype wire

// file: test/testbench.sv
// testbench of the tap detector and interrupt routing
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import tdr_pkg::*;
  localparam int HC = 10;
  logic       clk, rstn, regWrite, regRead, overThreshold, activeLow;
  logic       motionEventFirst, motionEventSecond, dataReady;
  logic       irqPinFirst, irqPinSecond, irq, hostFirst, hostSecond;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata;
  int         numErrors, nTests;
  tdr_top #(.HALF_CYC(HC)) DUT (.clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .motionEventFirst, .motionEventSecond, .dataReady, .overThreshold,
    .irqPinFirst, .irqPinSecond, .irq);
  tdr_host_model host (.padFirst(irqPinFirst), .padSecond(irqPinSecond), .activeLow,
    .eventFirst(hostFirst), .eventSecond(hostSecond));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic peak(input int n);
    @(posedge clk);
    overThreshold <= 1'b1;
    repeat (n) @(posedge clk);
    overThreshold <= 1'b0;
  endtask
  // source seen on a pad when no tap is pending
  function automatic logic pick(input logic [2:0] s, input logic [2:0] m);
    case (s)
      3'h1: return m[0];
      3'h2: return m[1];
      3'h3: return m[0] | m[1];
      3'h4: return m[2];
      default: return 1'b0;
    endcase
  endfunction
  task automatic t_route(input logic pol);
    for (int s = 0; s < 8; s++) begin
      activeLow = pol;
      wr(OFS_ROUTE, {pol, 1'b0, 3'(7 - s), s[2:0]});
      for (int m = 0; m < 8; m++) begin
        @(posedge clk);
        {dataReady, motionEventSecond, motionEventFirst} <= m[2:0];
        idle(2);
        check({7'h00, hostFirst}, {7'h00, pick(s[2:0], m[2:0])});
        check({7'h00, hostSecond}, {7'h00, pick(3'(7 - s), m[2:0])});
      end
    end
  endtask
  task automatic t_reset;
    logic [7:0] d;
    rd(OFS_ROUTE, d);
    check(d, 8'h87);
    wr(4'hf, 8'hff);
    rd(4'hf, d);
    check(d, 8'h00);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    activeLow = 1'b0;
    rd(OFS_ROUTE, d);
    check(d, 8'h00);
    check({6'h00, irqPinSecond, irqPinFirst}, 8'h00);
  endtask
  task automatic t_single;
    logic [7:0] d;
    wr(OFS_ROUTE, 8'h07);
    wr(OFS_TAPCFG, 8'h01);
    wr(OFS_DURATION, 8'h04);
    wr(OFS_MASK, 8'h01);
    rd(OFS_DURATION, d);
    check(d, 8'h04);
    peak(8 * HC);
    idle(4 * HC);
    check({7'h00, irq}, 8'h00);
    peak(HC);
    idle(4);
    check({6'h00, hostFirst, irq}, 8'h03);
    rd(OFS_STATUS, d);
    check(d, 8'h01);
    idle(2);
    check({7'h00, irq}, 8'h00);
  endtask
  task automatic t_double;
    logic [7:0] d;
    wr(OFS_TAPCFG, 8'h02);
    wr(OFS_QUIET, 8'h04);
    wr(OFS_WINDOW, 8'h04);
    wr(OFS_MASK, 8'h02);
    rd(OFS_QUIET, d);
    check(d, 8'h04);
    rd(OFS_WINDOW, d);
    check(d, 8'h04);
    rd(OFS_TAPCFG, d);
    check(d, 8'h02);
    rd(OFS_MASK, d);
    check(d, 8'h02);
    peak(HC);
    idle(4 * HC);
    peak(HC);
    idle(15 * HC);
    peak(HC);
    idle(4);
    rd(OFS_STATUS, d);
    check(d, 8'h00);
    idle(40 * HC);
    peak(HC);
    idle(10 * HC);
    peak(HC);
    idle(4);
    check({7'h00, irq}, 8'h01);
    rd(OFS_STATUS, d);
    check(d, 8'h02);
  endtask
  task automatic print_verdict;
    if (numErrors == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    // the tests need about 1400 cycles; this allows over ten times that
    #200_000;
    numErrors++;
    print_verdict;
  end
  initial begin
    {rstn, regWrite, regRead, overThreshold, activeLow} = 5'h00;
    {motionEventFirst, motionEventSecond, dataReady} = 3'h0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_route(1'b0);
    t_route(1'b1);
    t_reset;
    t_single;
    t_double;
    print_verdict;
  end
endmodule
bind tdr_top tdr_asserts chk (.clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead,
  .regRdata, .motionEventFirst, .motionEventSecond, .dataReady, .overThreshold,
  .irqPinFirst, .irqPinSecond, .irq);
`default_nettype wire
